// ===== licd_pkg.sv
// Purpose: shared constants, types and the command decoder for the init/decode block
// Assumes: 125 MHz core clock, one word per register on AHB-Lite
// Notes: the decoder module lives here beside the package it relies on
`timescale 1ns/1ps
`default_nettype none
package licd_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 8000;
    localparam int unsigned TZQINIT_NS = 1000;
    localparam int unsigned TINIT5_NS = 10000;
    // least time, rounded up
    localparam logic [7:0] TZQINIT_CYC =
        8'((TZQINIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    // longest time, rounded down
    localparam logic [10:0] TINIT5_CYC = 11'((TINIT5_NS * 1000) / CLK_PERIOD_PS);
    // burst of eight on a double rate bus
    localparam logic [2:0] AP_DELAY_CYC = 3'h4;

    // ------------------------------------------------------------
    // mode register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] MA_INFO = 8'h00;
    localparam logic [7:0] MA_ZQCAL = 8'h0a;
    localparam logic [7:0] MA_ODT = 8'h0b;
    localparam logic [7:0] MA_CAT_ENTRY1 = 8'h29;
    localparam logic [7:0] MA_CAT_EXIT = 8'h2a;
    localparam logic [7:0] MA_CAT_ENTRY2 = 8'h30;
    localparam logic [7:0] MA_RESET = 8'h3f;

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_LASTCMD = 8'h08;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;

    typedef enum logic [3:0]
    {
        CMD_NOP = 4'h0,
        CMD_MRW = 4'h1,
        CMD_MRR = 4'h2,
        CMD_REF_PB = 4'h3,
        CMD_REF_AB = 4'h4,
        CMD_ACT = 4'h5,
        CMD_WR = 4'h6,
        CMD_RD = 4'h7,
        CMD_PRE = 4'h8,
        CMD_SREF_IN = 4'h9,
        CMD_DPD_IN = 4'ha,
        CMD_PD_IN = 4'hb,
        CMD_PD_OUT = 4'hc,
        CMD_ILLEGAL = 4'hf
    } licd_cmd_t;

    typedef enum logic [3:0]
    {
        ST_POWER_ON = 4'h0,
        ST_PRE_RESET = 4'h1,
        ST_RESETTING = 4'h2,
        ST_RST_PD = 4'h3,
        ST_IDLE = 4'h4,
        ST_IDLE_PD = 4'h5,
        ST_ACT_PD = 4'h6,
        ST_SREF = 4'h7,
        ST_DPD = 4'h8
    } licd_state_t;

    // cs_n low plus ca0..ca3, ca0 in bit 0
    function automatic licd_cmd_t decode_cmd(input logic cs_n, input logic [3:0] ca);
        licd_cmd_t c;
        c = CMD_ILLEGAL;
        if (cs_n)
            c = CMD_NOP;
        else if (ca == 4'h0)
            c = CMD_MRW;
        else if (ca == 4'h8)
            c = CMD_MRR;
        else if (ca == 4'h4)
            c = CMD_REF_PB;
        else if (ca == 4'hc)
            c = CMD_REF_AB;
        else if (ca[1:0] == 2'h2)
            c = CMD_ACT;
        else if (ca[2:0] == 3'h1)
            c = CMD_WR;
        else if (ca[2:0] == 3'h5)
            c = CMD_RD;
        else if (ca == 4'hb)
            c = CMD_PRE;
        else if (ca[2:0] == 3'h7)
            c = CMD_NOP;
        return c;
    endfunction

endpackage

module licd_decode
(
    input wire logic cs_n,
    input wire logic [9:0] ca_r,
    input wire logic ca_z,
    input wire logic cke_prev,
    input wire logic cke_now,
    output licd_pkg::licd_cmd_t cmd
);
    import licd_pkg::*;

    always_comb
    begin
        cmd = CMD_NOP;
        if (cke_prev && !cke_now)
        begin
            if (cs_n)
                cmd = CMD_PD_IN;
            else if (ca_r[2:0] == 3'h3)
                cmd = CMD_DPD_IN;
            else if (ca_r[2:0] == 3'h4)
                cmd = CMD_SREF_IN;
            else
                cmd = CMD_ILLEGAL;
        end
        else if (!cke_prev && cke_now)
            cmd = cs_n ? CMD_PD_OUT : CMD_ILLEGAL;
        else if (cke_now && !ca_z)
            cmd = decode_cmd(cs_n, ca_r[3:0]);
    end

endmodule

`default_nettype wire

// ===== licd_core.sv
// Purpose: device-side init sequencing and command decode with AHB-Lite status port
// Assumes: pins sampled on clk after two flip-flops; hready is this slave's hreadyout
// Notes: zero wait state slave, OKAY only
//
// Overview of operation
// - ready tZQINIT after ZQ; then set MR1-3
// - floating command bus reads as NOP
// - termination off until MR11 after ZQ done
// - auto-init ends within 10 us, then idle
// - RESET restarts initialization from reset point
// - outputs high impedance while CKE low
// - decode commands from CS_n, CA0-3, CKE
// - precharge all when CA4 high, else bank
// - auto-precharge closes bank after burst
// - column bit zero always taken as zero
// - self refresh and deep power-down exit asynchronous
// - CKE rise with NOP leaves power-down
// - resetting power-down exit depends on auto-init expiry
// - MR0 read shows auto-init busy bit
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module licd_core
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic [9:0] ca_r,
    input wire logic [9:0] ca_f,
    input wire logic ca_z,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic [7:0] dq_out,
    output logic dq_oe,
    output logic odt_en,
    output logic [7:0] bank_open,
    output logic [11:0] col_addr,
    output logic [2:0] col_bank,
    output logic rd_pulse,
    output logic wr_pulse
);
    import licd_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [21:0] pin_m_q;
    logic [21:0] pin_s_q;
    logic cke_s;
    logic cs_n_s;
    logic ca_z_s;
    logic [9:0] ca_r_s;
    logic [9:0] ca_f_s;
    logic cke_prev_q;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_m_q <= 22'h000002;
            pin_s_q <= 22'h000002;
        end
        else
        begin
            pin_m_q <= {ca_f, ca_r, cs_n, cke};
            pin_s_q <= pin_m_q;
        end
    end

    assign cke_s = pin_s_q[0];
    assign cs_n_s = pin_s_q[1];
    assign ca_r_s = pin_s_q[11:2];
    assign ca_f_s = pin_s_q[21:12];

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cke_prev_q <= 1'b0;
        else
            cke_prev_q <= cke_s;
    end

    // ca_z travels separately so its reset value is high (floating bus)
    logic ca_z_m_q;
    logic ca_z_s_q;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ca_z_m_q <= 1'b1;
            ca_z_s_q <= 1'b1;
        end
        else
        begin
            ca_z_m_q <= ca_z;
            ca_z_s_q <= ca_z_m_q;
        end
    end

    assign ca_z_s = ca_z_s_q;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    licd_cmd_t cmd;
    logic [7:0] mrw_ma;
    logic [7:0] mrw_op;
    logic cmd_en_q;
    logic acc;
    logic is_reset;

    licd_decode u_dec
    (
        .cs_n(cs_n_s),
        .ca_r(ca_r_s),
        .ca_z(ca_z_s),
        .cke_prev(cke_prev_q),
        .cke_now(cke_s),
        .cmd(cmd)
    );

    assign mrw_ma = {ca_f_s[1:0], ca_r_s[9:4]};
    assign mrw_op = ca_f_s[9:2];
    assign is_reset = (cmd == CMD_MRW) && (mrw_ma == MA_RESET) && cmd_en_q;

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    licd_state_t state_q;
    logic [10:0] ainit_cnt_q;
    logic ainit_exp;
    logic ca_train_q;

    assign ainit_exp = (ainit_cnt_q == TINIT5_CYC);
    // training admits only RESET, NOP and the training entry and exit MRWs
    assign acc = cmd_en_q && !ca_train_q;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            state_q <= ST_POWER_ON;
        else if (is_reset && cke_s)
            state_q <= ST_RESETTING;
        else
        begin
            case (state_q)
                ST_POWER_ON:
                    if (cke_s)
                        state_q <= ST_PRE_RESET;
                ST_RESETTING:
                    if (ainit_exp)
                        state_q <= ST_IDLE;
                    else if (cmd == CMD_PD_IN)
                        state_q <= ST_RST_PD;
                ST_RST_PD:
                    if (cmd == CMD_PD_OUT)
                        state_q <= ainit_exp ? ST_IDLE : ST_RESETTING;
                ST_IDLE:
                    if (cmd == CMD_PD_IN && acc)
                        state_q <= (|bank_open) ? ST_ACT_PD : ST_IDLE_PD;
                    else if (cmd == CMD_SREF_IN && acc && !(|bank_open))
                        state_q <= ST_SREF;
                    else if (cmd == CMD_DPD_IN && acc && !(|bank_open))
                        state_q <= ST_DPD;
                ST_IDLE_PD, ST_ACT_PD, ST_SREF:
                    if (cmd == CMD_PD_OUT)
                        state_q <= ST_IDLE;
                ST_DPD:
                    if (cmd == CMD_PD_OUT)
                        state_q <= ST_POWER_ON;
                default:
                    state_q <= state_q;
            endcase
        end
    end

    // auto-init timer keeps running through resetting power-down
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ainit_cnt_q <= 11'h000;
        else if (is_reset && cke_s)
            ainit_cnt_q <= 11'h000;
        else if ((state_q == ST_RESETTING || state_q == ST_RST_PD) && !ainit_exp)
            ainit_cnt_q <= ainit_cnt_q + 11'h001;
    end

    // ------------------------------------------------------------
    // training, ZQ and termination
    // ------------------------------------------------------------
    logic idle_cmd;
    logic zq_go;
    logic [7:0] zq_cnt_q;
    logic zq_busy_q;
    logic zq_done_q;
    logic odt_q;

    assign idle_cmd = (state_q == ST_IDLE) && (cmd == CMD_MRW) && cmd_en_q;
    assign zq_go = idle_cmd && !ca_train_q && (mrw_ma == MA_ZQCAL) && !zq_busy_q && !zq_done_q;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ca_train_q <= 1'b0;
        else if (is_reset)
            ca_train_q <= 1'b0;
        else if (idle_cmd && (mrw_ma == MA_CAT_ENTRY1 || mrw_ma == MA_CAT_ENTRY2))
            ca_train_q <= 1'b1;
        else if (idle_cmd && mrw_ma == MA_CAT_EXIT)
            ca_train_q <= 1'b0;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            zq_cnt_q <= 8'h00;
            zq_busy_q <= 1'b0;
            zq_done_q <= 1'b0;
        end
        else if (is_reset)
        begin
            zq_cnt_q <= 8'h00;
            zq_busy_q <= 1'b0;
            zq_done_q <= 1'b0;
        end
        else if (zq_go)
        begin
            zq_cnt_q <= TZQINIT_CYC;
            zq_busy_q <= 1'b1;
            zq_done_q <= 1'b0;
        end
        else if (zq_busy_q)
        begin
            zq_cnt_q <= zq_cnt_q - 8'h01;
            if (zq_cnt_q == 8'h01)
            begin
                zq_busy_q <= 1'b0;
                zq_done_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            odt_q <= 1'b0;
        else if (is_reset)
            odt_q <= 1'b0;
        else if (idle_cmd && !ca_train_q && mrw_ma == MA_ODT && zq_done_q)
            odt_q <= mrw_op[0];
    end

    assign odt_en = odt_q;

    // ------------------------------------------------------------
    // banks and column path
    // ------------------------------------------------------------
    logic bank_cmd;
    logic [2:0] ba;
    logic ap_go;
    logic [2:0] ap_cnt_q;
    logic [2:0] ap_bank_q;
    logic [7:0] open_q;

    assign bank_cmd = (state_q == ST_IDLE) && acc;
    assign ba = ca_r_s[9:7];
    assign ap_go = bank_cmd && (cmd == CMD_RD || cmd == CMD_WR) && ca_f_s[0];

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ap_cnt_q <= 3'h0;
            ap_bank_q <= 3'h0;
        end
        else if (ap_go)
        begin
            ap_cnt_q <= AP_DELAY_CYC;
            ap_bank_q <= ba;
        end
        else if (ap_cnt_q != 3'h0)
            ap_cnt_q <= ap_cnt_q - 3'h1;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            open_q <= 8'h00;
        else if (is_reset)
            open_q <= 8'h00;
        else
        begin
            if (ap_cnt_q == 3'h1)
                open_q[ap_bank_q] <= 1'b0;
            if (bank_cmd && cmd == CMD_ACT)
                open_q[ba] <= 1'b1;
            else if (bank_cmd && cmd == CMD_PRE && ca_r_s[4])
                open_q <= 8'h00;
            else if (bank_cmd && cmd == CMD_PRE)
                open_q[ba] <= 1'b0;
        end
    end

    assign bank_open = open_q;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            col_addr <= 12'h000;
            col_bank <= 3'h0;
            rd_pulse <= 1'b0;
            wr_pulse <= 1'b0;
        end
        else
        begin
            rd_pulse <= bank_cmd && cmd == CMD_RD;
            wr_pulse <= bank_cmd && cmd == CMD_WR;
            if (bank_cmd && (cmd == CMD_RD || cmd == CMD_WR))
            begin
                col_addr <= {ca_f_s[9:1], ca_r_s[6:5], 1'b0};
                col_bank <= ba;
            end
        end
    end

    // ------------------------------------------------------------
    // mode register read path
    // ------------------------------------------------------------
    logic dai;

    assign dai = (state_q == ST_RESETTING || state_q == ST_RST_PD);

    // nothing drives while cke is low
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dq_oe <= 1'b0;
            dq_out <= 8'h00;
        end
        else
        begin
            dq_oe <= cke_s && cmd == CMD_MRR && acc && state_q != ST_PRE_RESET;
            if (cmd == CMD_MRR && mrw_ma == MA_INFO)
                dq_out <= {7'h00, dai};
            else if (cmd == CMD_MRR)
                dq_out <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    logic wr_ph_q;
    logic [7:0] wr_addr_q;
    logic [3:0] last_cmd_q;
    logic [15:0] last_mr_q;
    logic [31:0] rd_val;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (haddr[7:0] == REG_CTRL)
            rd_val = {31'h0000_0000, cmd_en_q};
        else if (haddr[7:0] == REG_STATUS)
            rd_val = {16'h0000, open_q, ca_train_q, odt_q, zq_done_q, dai, state_q};
        else if (haddr[7:0] == REG_LASTCMD)
            rd_val = {8'h00, last_mr_q, 4'h0, last_cmd_q};
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ph_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata <= 32'h0000_0000;
        end
        else if (hready)
        begin
            wr_ph_q <= hsel && htrans[1] && hwrite && hsize == 3'h2;
            wr_addr_q <= haddr[7:0];
            if (hsel && htrans[1] && !hwrite && haddr[31:8] == 24'h000000)
                hrdata <= rd_val;
            else
                hrdata <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cmd_en_q <= CTRL_RST[0];
        else if (wr_ph_q && wr_addr_q == REG_CTRL)
            cmd_en_q <= hwdata[0];
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            last_cmd_q <= 4'h0;
            last_mr_q <= 16'h0000;
        end
        else if (cmd != CMD_NOP)
        begin
            last_cmd_q <= cmd;
            last_mr_q <= {mrw_op, mrw_ma};
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    odt_after_zq_a: assert property (odt_q |-> zq_done_q)
        else $error("termination on before ZQ done");
    hiz_cke_low_a: assert property (!cke_s |=> !dq_oe)
        else $error("output enabled with cke low");
    ainit_max_a: assert property ((state_q == ST_RESETTING && ainit_exp && !is_reset)
        |=> state_q == ST_IDLE)
        else $error("auto-init overran its maximum");
    zq_wait_a: assert property (zq_go |=> (!zq_done_q)[*8])
        else $error("ZQ done too early");
    zq_rise_a: assert property ($rose(zq_done_q) |-> $past(zq_busy_q))
        else $error("ZQ done without calibration");
    reset_restart_a: assert property ((is_reset && cke_s)
        |=> state_q == ST_RESETTING && !odt_q && ainit_cnt_q == 11'h000)
        else $error("reset did not restart init");
    pre_all_a: assert property ((bank_cmd && cmd == CMD_PRE && ca_r_s[4] && !is_reset)
        |=> open_q == 8'h00)
        else $error("precharge all left a bank open");
    ap_close_a: assert property ((ap_go && !is_reset) |=> ##4 !open_q[ap_bank_q])
        else $error("auto-precharge did not close bank");
    col_zero_a: assert property ((bank_cmd && cmd == CMD_RD)
        |=> col_addr == {$past(ca_f_s[9:1]), $past(ca_r_s[6:5]), 1'b0})
        else $error("column address wrong");
    rstpd_exit_a: assert property ((state_q == ST_RST_PD && cmd == CMD_PD_OUT
        && !ainit_exp && !is_reset) |=> state_q == ST_RESETTING)
        else $error("resetting power-down exit wrong");
    float_nop_a: assert property ((ca_z_s && cke_s && cke_prev_q) |-> cmd == CMD_NOP)
        else $error("floating bus not a NOP");
    mrw_code_a: assert property ((!cs_n_s && !ca_z_s && cke_s && cke_prev_q
        && ca_r_s[3:0] == 4'h0) |-> cmd == CMD_MRW)
        else $error("MRW code misdecoded");
    pd_exit_c: cover property (state_q == ST_IDLE_PD ##1 state_q == ST_IDLE);
    zq_done_c: cover property ($rose(zq_done_q));
    dpd_c: cover property (state_q == ST_DPD ##1 state_q == ST_POWER_ON);

endmodule

`default_nettype wire

// ===== licd_ctl_model.sv
// Purpose: controller model driving the command pins
// Assumes: pins change just after a rising edge
// Notes: a released bus floats and its lines toggle
`timescale 1ns/1ps
`default_nettype none
module licd_ctl_model
(
    input wire logic clk,
    output logic cke,
    output logic cs_n,
    output logic [9:0] ca_r,
    output logic [9:0] ca_f,
    output logic ca_z
);
    import licd_pkg::*;
    // ------------------------------------------------
    // power-up waits, rounded up to whole cycles
    // ------------------------------------------------
    localparam int T_CKE = (100 + 7) / 8;
    localparam int T_IDLE = (200000 + 7) / 8;
    localparam int T_RST = (1000 + 7) / 8;
    initial
    begin
        cke = 1'b0;
        cs_n = 1'b1;
        ca_r = 10'h000;
        ca_f = 10'h000;
        ca_z = 1'b1;
    end
    task automatic nop(input int n);
        repeat (n)
        begin
            @(posedge clk);
            cs_n <= 1'b1;
            ca_z <= 1'b1;
            ca_r <= ~ca_r;
            ca_f <= ~ca_f;
        end
    endtask
    task automatic cmd(input logic [9:0] r, input logic [9:0] f, input logic z = 1'b0);
        @(posedge clk);
        cs_n <= 1'b0;
        ca_z <= z;
        ca_r <= r;
        ca_f <= f;
        nop(1);
    endtask
    task automatic mrw(input logic [7:0] ma, input logic [7:0] op);
        cmd({ma[5:0], 4'h0}, {op, ma[7:6]});
    endtask
    task automatic set_cke(input logic v);
        @(posedge clk);
        cke <= v;
        cs_n <= 1'b1;
    endtask
    // cke falls with cs_n low: self refresh or deep power-down entry
    task automatic pd_cmd(input logic [2:0] c);
        @(posedge clk);
        cke <= 1'b0;
        cs_n <= 1'b0;
        ca_z <= 1'b0;
        ca_r <= {7'h00, c};
        nop(1);
    endtask
    task automatic power_up();
        nop(T_CKE);
        set_cke(1'b1);
        nop(T_IDLE);
        mrw(MA_RESET, 8'h00);
        nop(T_RST);
    endtask
endmodule
`default_nettype wire

// ===== licd_core_tb.sv
// Purpose: self-checking bench for the init and decode core
// Assumes: controller model on the pins, bench on AHB-Lite
// Notes: state is read back through the status register
`timescale 1ns/1ps
`default_nettype none
module licd_core_tb;
    import licd_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cke, cs_n, ca_z, hreadyout, hresp, dq_oe, odt_en, rd_pulse, wr_pulse;
    logic [9:0] ca_r, ca_f;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, d;
    logic [7:0] dq_out, bank_open;
    logic [11:0] col_addr;
    logic [2:0] col_bank;
    logic [3:0] cas [3] = '{4'h8, 4'h4, 4'hc};
    logic [3:0] cexp [3] = '{CMD_MRR, CMD_REF_PB, CMD_REF_AB};
    int n_mismatch = 0;
    int check_count = 0;
    int n_rd = 0;
    int n_wr = 0;
    always #4 clk = ~clk;
    always @(posedge clk)
    begin
        if (rd_pulse === 1'b1) n_rd <= n_rd + 1;
        if (wr_pulse === 1'b1) n_wr <= n_wr + 1;
    end
    licd_ctl_model u_ctl (.clk(clk), .cke(cke), .cs_n(cs_n), .ca_r(ca_r), .ca_f(ca_f),
        .ca_z(ca_z));
    licd_core u_dut (.clk(clk), .arst_n(arst_n), .cke(cke), .cs_n(cs_n), .ca_r(ca_r),
        .ca_f(ca_f), .ca_z(ca_z), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dq_out(dq_out),
        .dq_oe(dq_oe), .odt_en(odt_en), .bank_open(bank_open), .col_addr(col_addr),
        .col_bank(col_bank), .rd_pulse(rd_pulse), .wr_pulse(wr_pulse));
    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic hwait();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1)
        begin
            n_mismatch++;
            summarize();
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
        input logic [2:0] sz = 3'h2);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= sz;
        hwait();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        hwait();
        d = hrdata;
    endtask
    task automatic st(input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, {24'h0, REG_STATUS}, 32'h0);
        chk(d & m, e);
    endtask
    task automatic act(input logic [2:0] b);
        u_ctl.cmd({b, 5'h00, 2'h2}, 10'h000);
    endtask
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_reset();
        bus(1'b1, {24'h0, REG_CTRL}, 32'h0, 3'h5);
        bus(1'b0, {24'h0, REG_CTRL}, 32'h0);
        chk(d, CTRL_RST);
        bus(1'b0, 32'h0000_0040, 32'h0);
        chk(d, 32'h0);
        bus(1'b0, 32'hffff_ff00, 32'h0);
        chk(d, 32'h0);
        st(32'hff, 32'h00);
        chk({hresp, dq_oe}, 2'h0);
    endtask
    task automatic t_init();
        int n;
        u_ctl.power_up();
        st(32'h1f, 32'h12);
        u_ctl.nop(1000);
        st(32'h1f, 32'h12);
        u_ctl.nop(150);
        st(32'h1f, 32'h04);
        n = 0;
        u_ctl.cmd({MA_INFO[5:0], 4'h8}, {8'h00, MA_INFO[7:6]});
        while (dq_oe !== 1'b1 && n < 8)
        begin
            @(negedge clk);
            n++;
        end
        chk({dq_oe, dq_out}, 9'h100);
        if (dq_oe !== 1'b1) summarize();
    endtask
    task automatic t_zq();
        u_ctl.mrw(MA_ODT, 8'h01);
        u_ctl.nop(5);
        chk(odt_en, 1'b0);
        u_ctl.mrw(MA_CAT_ENTRY1, 8'ha4);
        u_ctl.nop(4);
        st(32'h80, 32'h80);
        u_ctl.mrw(MA_CAT_EXIT, 8'ha8);
        u_ctl.nop(4);
        st(32'h80, 32'h00);
        u_ctl.mrw(MA_ZQCAL, 8'hff);
        u_ctl.nop(100);
        st(32'h20, 32'h00);
        u_ctl.nop(30);
        st(32'h20, 32'h20);
        u_ctl.mrw(MA_ODT, 8'h01);
        u_ctl.nop(5);
        chk(odt_en, 1'b1);
    endtask
    task automatic t_banks();
        act(3'd5);
        u_ctl.nop(5);
        chk(bank_open, 8'h20);
        u_ctl.cmd({3'd5, 2'h3, 5'h01}, {9'h155, 1'b0});
        u_ctl.nop(8);
        chk({n_wr[7:0], bank_open}, 16'h0120);
        chk({col_bank, col_addr}, {3'd5, 12'haae});
        u_ctl.cmd({3'd5, 2'h0, 5'h05}, {9'h000, 1'b1});
        u_ctl.nop(8);
        chk({n_rd[7:0], bank_open, col_addr}, 28'h0100000);
        act(3'd1);
        act(3'd2);
        u_ctl.cmd({3'd2, 3'h0, 4'hb}, 10'h000);
        u_ctl.nop(5);
        chk(bank_open, 8'h02);
        act(3'd6);
        u_ctl.cmd({3'd1, 3'h1, 4'hb}, 10'h000);
        u_ctl.nop(5);
        chk(bank_open, 8'h00);
    endtask
    task automatic t_regs();
        bus(1'b1, {24'h0, REG_CTRL}, 32'h0);
        act(3'd4);
        u_ctl.nop(5);
        chk(bank_open, 8'h00);
        bus(1'b1, {24'h0, REG_CTRL}, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            u_ctl.cmd({6'h00, cas[i]}, 10'h000);
            u_ctl.nop(4);
            bus(1'b0, {24'h0, REG_LASTCMD}, 32'h0);
            chk(d[3:0], cexp[i]);
        end
        u_ctl.cmd(10'h000, 10'h000, 1'b1);
        u_ctl.nop(4);
        bus(1'b0, {24'h0, REG_LASTCMD}, 32'h0);
        chk(d[3:0], CMD_REF_AB);
    endtask
    task automatic t_pd();
        u_ctl.set_cke(1'b0);
        u_ctl.nop(5);
        st(32'hf, 32'h5);
        u_ctl.set_cke(1'b1);
        u_ctl.nop(5);
        st(32'hf, 32'h4);
        act(3'd0);
        u_ctl.set_cke(1'b0);
        u_ctl.nop(5);
        st(32'hff0f, 32'h0106);
        u_ctl.set_cke(1'b1);
        u_ctl.nop(5);
        st(32'hff0f, 32'h0104);
        u_ctl.cmd({3'd0, 3'h1, 4'hb}, 10'h000);
        u_ctl.pd_cmd(3'h4);
        u_ctl.nop(5);
        st(32'hf, 32'h7);
        u_ctl.set_cke(1'b1);
        u_ctl.nop(5);
        st(32'hf, 32'h4);
    endtask
    task automatic t_rereset();
        u_ctl.mrw(MA_RESET, 8'h00);
        u_ctl.nop(5);
        st(32'h1f, 32'h12);
        chk(odt_en, 1'b0);
        u_ctl.set_cke(1'b0);
        u_ctl.nop(5);
        st(32'hf, 32'h3);
        u_ctl.set_cke(1'b1);
        u_ctl.nop(5);
        st(32'hf, 32'h2);
        u_ctl.set_cke(1'b0);
        u_ctl.nop(1300);
        u_ctl.set_cke(1'b1);
        u_ctl.nop(5);
        st(32'hf, 32'h4);
    endtask
    task automatic t_dpd();
        u_ctl.cmd(10'h003, 10'h000);
        u_ctl.nop(4);
        bus(1'b0, {24'h0, REG_LASTCMD}, 32'h0);
        chk(d[3:0], CMD_ILLEGAL);
        u_ctl.pd_cmd(3'h3);
        u_ctl.nop(5);
        st(32'hf, 32'h8);
        u_ctl.power_up();
        st(32'h1f, 32'h12);
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_init();
        t_zq();
        t_banks();
        t_regs();
        t_pd();
        t_rereset();
        t_dpd();
        summarize();
    end
endmodule
`default_nettype wire
